/* File: verification/pin_side_model.sv */
`timescale 1ns/1ps
module pin_side_model
  import counter_array_pkg::*;
(
  input  wire logic [NUM_MODULES-1:0] drive_lvl,
  input  wire logic [NUM_MODULES-1:0] module_pin_out,
  input  wire logic [NUM_MODULES-1:0] module_pin_oe_n,
  output logic      [NUM_MODULES-1:0] module_pin_in
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // one pin per module
  // The device wins while it drives, so a flip pin never fights the source
  always_comb begin
    for (int i = 0; i < NUM_MODULES; i++) begin
      module_pin_in[i] = module_pin_oe_n[i] ? drive_lvl[i] : module_pin_out[i];
    end
  end
endmodule : pin_side_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import counter_array_pkg::*;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  logic [ADDR_W-1:0]      reg_addr = '0;
  logic [DATA_W-1:0]      reg_wdata = '0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [DATA_W-1:0]      reg_rdata;
  logic                   twelve_clock_mode = 1'b0;
  logic                   cpu_idle = 1'b0;
  logic                   timer0_overflow = 1'b0;
  logic                   external_count_input = 1'b1;
  logic [NUM_MODULES-1:0] drive_lvl = '0;
  logic [NUM_MODULES-1:0] module_pin_in;
  logic [NUM_MODULES-1:0] module_pin_out;
  logic [NUM_MODULES-1:0] module_pin_oe_n;
  logic                   irq;
  logic                   watchdog_reset;
  logic [15:0]            v0;
  logic [15:0]            v1;
  logic [7:0]             d;
  int                     n_fail = 0;
  int                     tests_run = 0;
  int                     cyc = 0;
  int                     wd_hits = 0;
  logic                   pwm_win = 1'b0;
  int                     pwm_hi = 0;
  int                     exp_ticks [4] = '{20, 10, 60, 30};

  always #20 clk = ~clk;

  counter_array u_counter_array (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .twelve_clock_mode(twelve_clock_mode),
    .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input), .module_pin_in(module_pin_in),
    .module_pin_out(module_pin_out), .module_pin_oe_n(module_pin_oe_n), .irq(irq),
    .watchdog_reset(watchdog_reset)
  );

  pin_side_model u_pin_side_model (
    .drive_lvl(drive_lvl), .module_pin_out(module_pin_out),
    .module_pin_oe_n(module_pin_oe_n), .module_pin_in(module_pin_in)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Overflow test alone needs about 66k cycles
  always @(posedge clk) begin
    cyc++;
    if (watchdog_reset === 1'b1) wd_hits++;
    // Window flag is set by non-blocking assignment, so the sample count is exact
    if (pwm_win && module_pin_out[2] === 1'b1) pwm_hi++;
    if (cyc == 100000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic rdv(input int n, output logic [15:0] v);
    rd({GRP_VLOW, 3'(n)}, v[7:0]);
    rd({GRP_VHIGH, 3'(n)}, v[15:8]);
  endtask : rdv

  task automatic t0_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      timer0_overflow <= 1'b1;
      @(posedge clk);
      timer0_overflow <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask : t0_pulses

  // Rising edge on a module pin, then read back what it captured
  task automatic grab(input int n, output logic [15:0] v);
    @(posedge clk);
    drive_lvl[n] <= 1'b1;
    repeat (3) @(posedge clk);
    drive_lvl[n] <= 1'b0;
    repeat (2) @(posedge clk);
    rdv(n, v);
  endtask : grab

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(5'h00, d); chk(d, MODE_RST);
    rd(5'h01, d); chk(d, CTRL_RST);
    rd(5'h08, d); chk(d, MMODE_RST);
    wr(5'h00, 8'hFF); rd(5'h00, d); chk(d, 8'hC7);
    wr(5'h08, 8'hFF); rd(5'h08, d); chk(d, 8'h7F);
    wr(5'h0D, 8'hFF); rd(5'h0D, d); chk(d, 8'h00);
    wr(5'h13, 8'hA5); wr(5'h1B, 8'h5A); rdv(3, v0); chk(v0, 16'h5AA5);
    wr(5'h00, 8'h00);
    wr(5'h08, 8'h20);
    wr(5'h09, 8'h20);
    $display("test registers finished");

    for (int k = 0; k < 4; k++) begin
      twelve_clock_mode <= k[0];
      wr(5'h00, {5'h00, 1'b0, k[1], 1'b0});
      wr(5'h01, 8'h40);
      repeat (16) @(posedge clk);
      drive_lvl[0] <= 1'b1;
      repeat (120) @(posedge clk);
      drive_lvl[1] <= 1'b1;
      repeat (4) @(posedge clk);
      drive_lvl <= '0;
      rdv(0, v0);
      rdv(1, v1);
      chk(v1 - v0, 16'(exp_ticks[k]));
    end
    $display("test internal sources finished");

    wr(5'h00, 8'h84);
    cpu_idle <= 1'b1;
    grab(0, v0); t0_pulses(5); grab(1, v1); chk(v1 - v0, 16'h0000);
    cpu_idle <= 1'b0;
    grab(0, v0); t0_pulses(5); grab(1, v1); chk(v1 - v0, 16'h0005);
    wr(5'h01, 8'h00);
    grab(0, v0); t0_pulses(5); grab(1, v1); chk(v1 - v0, 16'h0000);
    wr(5'h01, 8'h40);
    wr(5'h00, 8'h06);
    grab(0, v0);
    repeat (4) begin
      @(posedge clk);
      external_count_input <= 1'b0;
      repeat (2) @(posedge clk);
      external_count_input <= 1'b1;
      repeat (2) @(posedge clk);
    end
    grab(1, v1); chk(v1 - v0, 16'h0004);
    $display("test event sources finished");

    wr(5'h00, 8'h04);
    grab(0, v0);
    v1 = v0 + 16'h0003;
    wr(5'h12, v1[7:0]);
    wr(5'h1A, v1[15:8]);
    wr(5'h13, v1[7:0]);
    wr(5'h1B, v1[15:8]);
    wr(5'h0A, 8'h49);
    wr(5'h0B, 8'h44);
    wr(5'h01, 8'h40);
    @(posedge clk);
    #1 chk(module_pin_oe_n[3], 1'b0);
    chk(module_pin_out[3], 1'b1);
    t0_pulses(3);
    rd(5'h01, d); chk(d, 8'h44);
    chk(irq, 1'b1);
    chk(module_pin_out[3], 1'b0);
    wr(5'h01, 8'h40);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    $display("test compare finished");

    wr(5'h0A, 8'h00);
    wr(5'h00, 8'h45);
    wr(5'h14, 8'h00);
    wr(5'h1C, 8'h80);
    wr(5'h0C, 8'h40);
    wr(5'h01, 8'h40);
    grab(0, v0);
    wd_hits = 0;
    @(posedge clk);
    timer0_overflow <= 1'b1;
    repeat (65536 - int'(v0) + 8) @(posedge clk);
    timer0_overflow <= 1'b0;
    repeat (3) @(posedge clk);
    rd(5'h01, d); chk(d[7], 1'b1);
    chk(irq, 1'b1);
    chk(16'(wd_hits), 16'h0001);
    repeat (20) @(posedge clk);
    rd(5'h01, d); chk(d[7], 1'b1);
    wr(5'h00, 8'h04);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(5'h01, 8'h40);
    rd(5'h01, d); chk(d, 8'h40);
    $display("test overflow finished");

    wr(5'h12, 8'h80);
    wr(5'h1A, 8'h80);
    wr(5'h0A, 8'h42);
    @(posedge clk);
    timer0_overflow <= 1'b1;
    repeat (4) @(posedge clk);
    pwm_win <= 1'b1;
    repeat (256) @(posedge clk);
    pwm_win <= 1'b0;
    timer0_overflow <= 1'b0;
    @(posedge clk);
    #1 chk(module_pin_oe_n[2], 1'b0);
    chk(16'(pwm_hi), 16'h0080);
    $display("test pwm finished");
    complete_run();
  end
endmodule : tb_top

/* File: verilog/cc_slice.sv */
`timescale 1ns/1ps
module cc_slice
  import counter_array_pkg::*;
(
  input  logic              clk,
  input  logic              srst,
  input  logic              advance,
  input  logic [CNT_W-1:0]  count_q,
  input  logic [CNT_W-1:0]  count_next,
  input  logic [DATA_W-1:0] mode,
  input  logic [CNT_W-1:0]  value,
  input  logic              pin_in,
  output logic              hit,
  output logic              grab,
  output logic              pin_out,
  output logic              pin_oe_n
);

  logic              pin_prev_q;
  logic              pin_q;
  logic [DATA_W-1:0] pwm_ref_q;
  logic              pwm_on;

  assign pwm_on = mode[MM_PWM] & mode[MM_CMP_EN];
  // Hit is flagged in the cycle the time base steps onto the value
  assign hit    = mode[MM_CMP_EN] & advance & (count_next == value);
  assign grab   = (mode[MM_RISE_GRAB] & ~pin_prev_q & pin_in)
                | (mode[MM_FALL_GRAB] & pin_prev_q & ~pin_in);

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_in;
    end
  end

  // Reference reloads from the high byte only at low-byte wrap: no glitched periods
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_ref_q <= 8'h00;
    end else if (!pwm_on) begin
      pwm_ref_q <= value[DATA_W-1:0];
    end else if (advance && count_next[DATA_W-1:0] == 8'h00) begin
      pwm_ref_q <= value[CNT_W-1:DATA_W];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_q <= 1'b1;
    end else if (pwm_on) begin
      pin_q <= count_q[DATA_W-1:0] >= pwm_ref_q;
    end else if (hit && mode[MM_FLIP]) begin
      pin_q <= ~pin_q;
    end
  end

  assign pin_out  = pin_q;
  assign pin_oe_n = ~(mode[MM_CMP_EN] & (mode[MM_PWM] | mode[MM_FLIP]));

endmodule : cc_slice

/* File: verilog/count_tick_source.sv */
`timescale 1ns/1ps
module count_tick_source
  import counter_array_pkg::*;
(
  input  logic          clk,
  input  logic          srst,
  input  count_src_type src,
  input  logic          twelve_clock_mode,
  input  logic          timer0_overflow,
  input  logic          external_count_input,
  output logic          tick
);

  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] div_last;
  logic               ext_prev_q;
  logic               tick_q;

  always_comb begin
    case (src)
      SRC_OSC_SLOW: div_last = (twelve_clock_mode ? DIV_SLOW_12 : DIV_SLOW_6) - PRESC_ONE;
      SRC_OSC_FAST: div_last = (twelve_clock_mode ? DIV_FAST_12 : DIV_FAST_6) - PRESC_ONE;
      default:      div_last = PRESC_ZERO;
    endcase
  end

  // Prescaler free-runs so a source change takes effect within one period
  always_ff @(posedge clk) begin
    if (srst || presc_q >= div_last) begin
      presc_q <= PRESC_ZERO;
    end else begin
      presc_q <= presc_q + PRESC_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= external_count_input;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_q <= 1'b0;
    end else begin
      case (src)
        SRC_OSC_SLOW: tick_q <= presc_q == div_last;
        SRC_OSC_FAST: tick_q <= presc_q == div_last;
        SRC_TIMER0:   tick_q <= timer0_overflow;
        SRC_EXT:      tick_q <= ext_prev_q & ~external_count_input;
        default:      tick_q <= 1'b0;
      endcase
    end
  end

  assign tick = tick_q;

endmodule : count_tick_source

/* File: verilog/counter_array.sv */
// Summary of operation
// (RULE1) One shared 16-bit up-counting time base feeds five 16-bit modules.
// (RULE2) Each module does capture, software timer, flip output or PWM.
// (RULE3) Module n owns one port pin, module 0 lowest, ascending by index.
// (RULE4) Select 00 counts oscillator over six, or over twelve in twelve-clock mode.
// (RULE5) Select 01 counts oscillator over two, or over four in twelve-clock mode.
// (RULE6) Select 1x counts Timer 0 overflows, or external input edges when low bit set; the code counts falling edges only.
// (RULE7) Idle-stop set halts the time base while the processor idles.
// (RULE8) Watchdog enable turns module 4 watchdog reset on or off.
// (RULE9) Overflow flag with overflow enable set raises the interrupt request.
// (RULE10) Run control at control bit 6 starts the counter; clearing it stops.
// (RULE11) Overflow sets control bit 7; only software may clear it.
// (RULE12) Control bits 0 to 4 are module event flags, cleared by software only.
// (RULE13) Module mode bit 0 lets its event flag request an interrupt.
// (RULE14) Module mode bit 1 selects pulse width modulation.
// (RULE15) Module mode bit 2 flips the pin on every compare hit; the code does not flip it while PWM mode is also set.
// (RULE16) Module mode bit 3 sets the event flag on every compare hit.
// (RULE17) Mode bit 4 captures falling edges, bit 5 rising, both capture either.
// (RULE18) Module mode bit 6 enables the comparator against the stored value.
// (RULE19) Capture stores the 16-bit count; compare modes match against it.
// (RULE20) In PWM the value bytes set the output duty cycle.
// (RULE21) Counter steps once per count event and flags overflow on wrap to zero.
`timescale 1ns/1ps
module counter_array
  import counter_array_pkg::*;
(
  input  logic                   clk,
  input  logic                   srst,
  input  logic [ADDR_W-1:0]      reg_addr,
  input  logic [DATA_W-1:0]      reg_wdata,
  input  logic                   reg_wr,
  input  logic                   reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  input  logic                   twelve_clock_mode,
  input  logic                   cpu_idle,
  input  logic                   timer0_overflow,
  input  logic                   external_count_input,
  input  logic [NUM_MODULES-1:0] module_pin_in,
  output logic [NUM_MODULES-1:0] module_pin_out,
  output logic [NUM_MODULES-1:0] module_pin_oe_n,
  output logic                   irq,
  output logic                   watchdog_reset
);

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  localparam logic [2:0] SLOT_LIMIT = 3'(NUM_MODULES);

  logic [DATA_W-1:0]      mode_q;
  logic [DATA_W-1:0]      ctrl_q;
  logic [DATA_W-1:0]      ctrl_d;
  logic [DATA_W-1:0]      mmode_q [NUM_MODULES];
  logic [CNT_W-1:0]       value_q [NUM_MODULES];
  logic [CNT_W-1:0]       count_q;
  logic [CNT_W-1:0]       count_next;
  logic [DATA_W-1:0]      rd_d;
  logic [DATA_W-1:0]      rdata_q;
  logic [NUM_MODULES-1:0] hit;
  logic [NUM_MODULES-1:0] grab;
  logic [NUM_MODULES-1:0] event_vec;
  logic [NUM_MODULES-1:0] irq_en_vec;
  logic [1:0]             grp;
  logic [2:0]             idx;
  logic                   slot_ok;
  logic                   tick;
  logic                   running;
  logic                   advance;
  logic                   ovf;
  logic                   irq_q;
  logic                   wdog_q;
  logic                   ctrl_wr;
  count_src_type          src;

  assign grp     = reg_addr[ADDR_W-1:3];
  assign idx     = reg_addr[2:0];
  assign slot_ok = idx < SLOT_LIMIT;
  assign ctrl_wr = reg_wr && grp == GRP_ARRAY && idx == IDX_CTRL;

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= MODE_RST;
    end else if (reg_wr && grp == GRP_ARRAY && idx == IDX_MODE) begin
      mode_q <= reg_wdata & MODE_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // (RULE4) (RULE5) (RULE6) source select
  assign src = count_src_type'({mode_q[MODE_SEL_HI], mode_q[MODE_SEL_LO]});

  count_tick_source u_tick (
    .clk                  (clk),
    .srst                 (srst),
    .src                  (src),
    .twelve_clock_mode    (twelve_clock_mode),
    .timer0_overflow      (timer0_overflow),
    .external_count_input (external_count_input),
    .tick                 (tick)
  );

  // (RULE10) run control gate
  // (RULE7) idle stop gate
  assign running = ctrl_q[CTRL_RUN] & ~(mode_q[MODE_IDLE_STOP] & cpu_idle);
  assign advance = running & tick;
  // (RULE21) step and wrap
  assign count_next = count_q + CNT_ONE;
  assign ovf        = advance && count_q == CNT_MAX;

  // (RULE1) shared time base
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= VALUE_RST;
    end else if (advance) begin
      count_q <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // Control and flags
  // ----------------------------------------------------------------
  // Hardware set is applied after the software write, so a hit in the
  // same cycle as a clear is kept.
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = reg_wdata & CTRL_WMASK;
    end
    // (RULE11) overflow flag set
    if (ovf) begin
      ctrl_d[CTRL_OVF] = 1'b1;
    end
    // (RULE12) module flag set
    for (int k = 0; k < NUM_MODULES; k++) begin
      if (event_vec[k]) begin
        ctrl_d[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Modules
  // ----------------------------------------------------------------
  // (RULE2) per-module function
  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
    localparam logic [2:0] SLOT = 3'(i);
    logic sel;

    assign sel = idx == SLOT;

    // (RULE14) (RULE18) mode register
    always_ff @(posedge clk) begin
      if (srst) begin
        mmode_q[i] <= MMODE_RST;
      end else if (reg_wr && grp == GRP_MMODE && sel) begin
        mmode_q[i] <= reg_wdata & MMODE_WMASK;
      end
    end

    // (RULE19) capture beats software write
    always_ff @(posedge clk) begin
      if (srst) begin
        value_q[i] <= VALUE_RST;
      end else if (grab[i]) begin
        value_q[i] <= count_q;
      end else if (reg_wr && grp == GRP_VLOW && sel) begin
        value_q[i][DATA_W-1:0] <= reg_wdata;
      end else if (reg_wr && grp == GRP_VHIGH && sel) begin
        value_q[i][CNT_W-1:DATA_W] <= reg_wdata;
      end
    end

    // (RULE3) (RULE15) (RULE17) (RULE20) pin logic
    cc_slice u_slice (
      .clk        (clk),
      .srst       (srst),
      .advance    (advance),
      .count_q    (count_q),
      .count_next (count_next),
      .mode       (mmode_q[i]),
      .value      (value_q[i]),
      .pin_in     (module_pin_in[i]),
      .hit        (hit[i]),
      .grab       (grab[i]),
      .pin_out    (module_pin_out[i]),
      .pin_oe_n   (module_pin_oe_n[i])
    );

    // (RULE16) hit sets flag
    assign event_vec[i]  = grab[i] | (hit[i] & mmode_q[i][MM_HIT_FLAG]);
    assign irq_en_vec[i] = mmode_q[i][MM_IRQ_EN];
  end

  // ----------------------------------------------------------------
  // Interrupt request and watchdog
  // ----------------------------------------------------------------
  // (RULE9) (RULE13) request combine
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ctrl_q[CTRL_OVF] & mode_q[MODE_OVF_IE])
             | (|(ctrl_q[NUM_MODULES-1:0] & irq_en_vec));
    end
  end

  // (RULE8) watchdog reset pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      wdog_q <= 1'b0;
    end else begin
      wdog_q <= mode_q[MODE_WDOG_EN] & hit[WDOG_MODULE];
    end
  end

  assign irq            = irq_q;
  assign watchdog_reset = wdog_q;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    case (grp)
      GRP_ARRAY: begin
        if (idx == IDX_MODE) begin
          rd_d = mode_q;
        end else if (idx == IDX_CTRL) begin
          rd_d = ctrl_q;
        end
      end
      GRP_MMODE: begin
        if (slot_ok) begin
          rd_d = mmode_q[idx];
        end
      end
      GRP_VLOW: begin
        if (slot_ok) begin
          rd_d = value_q[idx][DATA_W-1:0];
        end
      end
      GRP_VHIGH: begin
        if (slot_ok) begin
          rd_d = value_q[idx][CNT_W-1:DATA_W];
        end
      end
      default: rd_d = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_d : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_ovf_set;
    ovf |=> ctrl_q[CTRL_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // RULE11

  property p_ovf_sticky;
    ctrl_q[CTRL_OVF] && !ctrl_wr |=> ctrl_q[CTRL_OVF];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost"); // RULE11

  property p_step;
    advance |=> count_q == $past(count_next);
  endproperty
  a_step: assert property (p_step) else $error("time base did not step"); // RULE21

  property p_stopped;
    !ctrl_q[CTRL_RUN] [*2] |-> $stable(count_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("time base moved while stopped"); // RULE10

  property p_idle_hold;
    (mode_q[MODE_IDLE_STOP] && cpu_idle) |=> count_q == $past(count_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("time base moved in idle"); // RULE7

  property p_capture;
    grab[0] |=> value_q[0] == $past(count_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // RULE19

  property p_flag;
    event_vec[0] |=> ctrl_q[0] ##1 (ctrl_q[0] || $past(ctrl_wr));
  endproperty
  a_flag: assert property (p_flag) else $error("module flag not kept"); // RULE12

  property p_irq;
    ctrl_q[CTRL_OVF] && mode_q[MODE_OVF_IE] |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request missing"); // RULE9

  property p_no_irq;
    !(ctrl_q[CTRL_OVF] && mode_q[MODE_OVF_IE])
      && !(|(ctrl_q[NUM_MODULES-1:0] & irq_en_vec)) |=> !irq_q;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("spurious request"); // RULE13

  property p_wdog;
    mode_q[MODE_WDOG_EN] && hit[WDOG_MODULE] |=> watchdog_reset;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset missing"); // RULE8

  // Module 3 is the one that the scenarios run as a flip output
  property p_flip;
    hit[3] && mmode_q[3][MM_FLIP] && !mmode_q[3][MM_PWM]
      |=> module_pin_out[3] != $past(module_pin_out[3]);
  endproperty
  a_flip: assert property (p_flip) else $error("pin did not flip"); // RULE15

  c_ovf:     cover property (ovf);
  c_capture: cover property (grab[0] ##1 ctrl_q[0]);
  c_flip:    cover property (hit[3] && mmode_q[3][MM_FLIP]);
  c_irq:     cover property (!irq_q ##1 irq_q);

endmodule : counter_array

/* File: verilog/counter_array_pkg.sv */
package counter_array_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_MODULES = 5;
  localparam int CNT_W       = 16;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 5;
  localparam int PRESC_W     = 4;
  localparam int WDOG_MODULE = 4;

  // ----------------------------------------------------------------
  // Address map: addr[4:3] selects a group, addr[2:0] the slot
  // ----------------------------------------------------------------
  localparam logic [1:0] GRP_ARRAY = 2'h0;
  localparam logic [1:0] GRP_MMODE = 2'h1;
  localparam logic [1:0] GRP_VLOW  = 2'h2;
  localparam logic [1:0] GRP_VHIGH = 2'h3;
  localparam logic [2:0] IDX_MODE  = 3'h0;
  localparam logic [2:0] IDX_CTRL  = 3'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_IDLE_STOP = 7;
  localparam int MODE_WDOG_EN   = 6;
  localparam int MODE_SEL_HI    = 2;
  localparam int MODE_SEL_LO    = 1;
  localparam int MODE_OVF_IE    = 0;
  localparam int CTRL_OVF       = 7;
  localparam int CTRL_RUN       = 6;
  localparam int MM_IRQ_EN      = 0;
  localparam int MM_PWM         = 1;
  localparam int MM_FLIP        = 2;
  localparam int MM_HIT_FLAG    = 3;
  localparam int MM_FALL_GRAB   = 4;
  localparam int MM_RISE_GRAB   = 5;
  localparam int MM_CMP_EN      = 6;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] MODE_RST    = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_RST    = 8'h00;
  localparam logic [DATA_W-1:0] MMODE_RST   = 8'h00;
  localparam logic [CNT_W-1:0]  VALUE_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] MODE_WMASK  = 8'hC7;
  localparam logic [DATA_W-1:0] CTRL_WMASK  = 8'hDF;
  localparam logic [DATA_W-1:0] MMODE_WMASK = 8'h7F;
  localparam logic [CNT_W-1:0]  CNT_MAX     = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 16'h0001;

  // ----------------------------------------------------------------
  // Prescaler divisors for six- and twelve-clock timing
  // ----------------------------------------------------------------
  localparam logic [PRESC_W-1:0] DIV_SLOW_6  = 4'h6;
  localparam logic [PRESC_W-1:0] DIV_SLOW_12 = 4'hC;
  localparam logic [PRESC_W-1:0] DIV_FAST_6  = 4'h2;
  localparam logic [PRESC_W-1:0] DIV_FAST_12 = 4'h4;
  localparam logic [PRESC_W-1:0] PRESC_ONE   = 4'h1;
  localparam logic [PRESC_W-1:0] PRESC_ZERO  = 4'h0;

  typedef enum logic [1:0] {
    SRC_OSC_SLOW,
    SRC_OSC_FAST,
    SRC_TIMER0,
    SRC_EXT
  } count_src_type;

endpackage : counter_array_pkg
